// ### rtl/svp_port.sv
`timescale 1ns/10ps
`include "svp_consts.svh"
// Summary of operation
// - six-bit command, optional sixteen-bit word, LSB first
// - data line sampled on programmer clock falling edge
// - fourteen payload bits framed by two zeros
// - load codes: configuration, program word, data byte
// - increment, read program, read data codes
// - erase-program, program-only, setup two fully decoded
// - bulk erase codes and setup one code
// - loads shift in, reads drive data out
// - pointer zero on entry; load configuration sets 0x2000
// - pointer wraps within user or configuration half
// - configuration half is sticky until mode exit
// - 0x2000-0x200F present, above reaches user memory
// - identification words read true under protection
// - rest of device held reset, pins floating
// - high voltage ignored once low-voltage mode entered
// - entry pin works only when enable bit set
// - program load latches fourteen-bit word for pointer
// - data load latches byte, all sixteen clocks needed
// - program-only writes loaded word, self-timed, no erase
// - erase-program erases then writes word, self-timed
// - read drives from second rising to sixteenth edge
// - data read returns byte, remaining bits zero
// - increment command advances pointer by one
module svp_port
  import svp_pkg::*;
#(
  parameter int DATA_ADDR_BITS = `SVP_DATA_ADDR_W,
  parameter int RD_LAT_MAX     = `SVP_RD_LAT_MAX
)(
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   link_clk_in,
  input  wire logic                   prog_data_in,
  output logic                        prog_data_out,
  output logic                        prog_data_oe_n_out,
  input  wire logic                   program_mode_select_hv_in,
  input  wire logic                   program_mode_select_pin_in,
  input  wire logic                   low_voltage_entry_pin_in,
  input  wire logic                   low_voltage_programming_bit_in,
  output logic                        mode_active_out,
  output logic                        lv_mode_out,
  output logic                        core_hold_out,
  output logic                        io_hiz_out,
  output logic                        nvm_req_out,
  output svp_op_t                     nvm_op_out,
  output logic                        nvm_data_space_out,
  output logic                        nvm_cfg_sel_out,
  output logic [`SVP_ADDR_W-1:0]      nvm_addr_out,
  output logic [`SVP_PAY_W-1:0]       nvm_wdata_out,
  input  wire logic                   nvm_rvalid_in,
  input  wire logic [`SVP_PAY_W-1:0]  nvm_rdata_in,
  input  wire logic                   nvm_protect_in
);

  // the read word must be fetched well inside the command-to-data gap
  if (RD_LAT_MAX + `SVP_SYNC_CYC >= `SVP_GAP_CYC)
  begin : g_bad_lat
    $error("read latency does not fit the command to data gap");
  end
  if (DATA_ADDR_BITS < 1 || DATA_ADDR_BITS > `SVP_ADDR_W)
  begin : g_bad_daddr
    $error("data address width out of range");
  end

  localparam svp_lneg_t LNEG_RST = '{
    phase: LK_CMD, cnt: `SVP_CNT_RST, cmd: `SVP_ZERO_CMD, sh: `SVP_ZERO_WORD,
    is_read: 1'b0, ev_cmd: `SVP_ZERO_CMD, tog: 1'b0};
  localparam svp_lpos_t LPOS_RST = '{dout: 1'b0, oe_n: 1'b1};
  localparam svp_core_t CORE_RST = '{
    mode: MODE_OFF, ptr: `SVP_PTR_RST, ld_word: `SVP_ZERO_PAY, ld_dspace: 1'b0,
    rword: `SVP_ZERO_WORD, rd_pend: 1'b0, rd_dspace: 1'b0, rd_id: 1'b0,
    tog_s: 2'h0, tog_prev: 1'b0, hv_s: 2'h0, sel_s: 2'h0, lve_s: 2'h0,
    lvp_s: 2'h0, link_hold: 1'b1, hold: 1'b0, lv: 1'b0, req: 1'b0,
    op: OP_READ, dspace: 1'b0, cfg_sel: 1'b0, addr: `SVP_ZERO_ADDR,
    wdata: `SVP_ZERO_PAY};

  svp_lneg_t ln_r;
  svp_lneg_t ln_next;
  svp_lpos_t lp_r;
  svp_lpos_t lp_next;
  svp_core_t c_r;
  svp_core_t c_next;
  logic      link_hold;
  svp_cmd_t  lk_kind;
  svp_cmd_t  ev_kind;
  logic      ev;
  logic      lv_ok;

  // next pointer: count in the low bits, top bit never changes
  function automatic logic [`SVP_PTR_W-1:0] ptr_inc(input logic [`SVP_PTR_W-1:0] p);
    return {p[`SVP_PTR_W-1], `SVP_ADDR_W'(p[`SVP_ADDR_W-1:0] + `SVP_PTR_STEP)};
  endfunction : ptr_inc

  // configuration select only for the sixteen implemented words
  function automatic logic cfg_hit(input logic [`SVP_PTR_W-1:0] p);
    return p[`SVP_PTR_W-1] && (p[`SVP_ADDR_W-1:4] == `SVP_CFG_HI_ZERO);
  endfunction : cfg_hit

  // array address of the pointer for either memory
  function automatic logic [`SVP_ADDR_W-1:0] phys_addr(
    input logic [`SVP_PTR_W-1:0] p,
    input logic                  dspace
  );
    logic [`SVP_ADDR_W-1:0] a;
    a = p[`SVP_ADDR_W-1:0];
    if (dspace)
      a = a & `SVP_ADDR_W'((1 << DATA_ADDR_BITS) - 1);
    return a;
  endfunction : phys_addr

  // issue one array request at the current pointer
  function automatic svp_core_t issue(
    input svp_core_t s,
    input svp_op_t   op,
    input logic      dspace
  );
    svp_core_t t;
    t = s;
    t.req = 1'b1;
    t.op = op;
    t.dspace = dspace;
    t.cfg_sel = dspace ? 1'b0 : cfg_hit(s.ptr);
    t.addr = phys_addr(s.ptr, dspace);
    t.wdata = s.ld_word;
    return t;
  endfunction : issue

  assign link_hold = c_r.link_hold;

  // falling edge: shift command and data bits in
  always_comb
  begin
    ln_next = ln_r;
    lk_kind = svp_decode({prog_data_in, ln_r.cmd[`SVP_CMD_W-1:1]});
    unique case (ln_r.phase)
      LK_CMD:
      begin
        ln_next.cmd = {prog_data_in, ln_r.cmd[`SVP_CMD_W-1:1]};
        ln_next.cnt = 5'(ln_r.cnt + `SVP_CNT_STEP);
        if (ln_r.cnt == `SVP_CMD_LAST)
        begin
          ln_next.cnt = `SVP_CNT_RST;
          ln_next.ev_cmd = ln_next.cmd;
          ln_next.is_read = svp_is_read(lk_kind);
          if (svp_has_data(lk_kind))
            ln_next.phase = LK_DATA;
          // reads go to the core now so the word is ready after the gap
          if (!svp_has_data(lk_kind) || svp_is_read(lk_kind))
            ln_next.tog = ~ln_r.tog;
        end
      end
      LK_DATA:
      begin
        ln_next.sh = {prog_data_in, ln_r.sh[`SVP_WORD_W-1:1]};
        ln_next.cnt = 5'(ln_r.cnt + `SVP_CNT_STEP);
        // frame ends only after all sixteen clocks
        if (ln_r.cnt == `SVP_WORD_LAST)
        begin
          ln_next.phase = LK_CMD;
          ln_next.cnt = `SVP_CNT_RST;
          if (!ln_r.is_read)
            ln_next.tog = ~ln_r.tog;
        end
      end
    endcase
  end

  // link side is cleared while out of mode; programmer clock idles then
  always_ff @(negedge link_clk_in or posedge link_hold)
  begin
    if (link_hold)
      ln_r <= LNEG_RST;
    else
      ln_r <= ln_next;
  end

  // rising edge: present read bits one to fifteen
  always_comb
  begin
    lp_next = LPOS_RST;
    if (ln_r.phase == LK_DATA && ln_r.is_read && ln_r.cnt != `SVP_CNT_RST)
    begin
      lp_next.oe_n = 1'b0;
      // core word is static since the command end, gap covers the crossing
      lp_next.dout = c_r.rword[ln_r.cnt[3:0]];
    end
  end

  always_ff @(posedge link_clk_in or posedge link_hold)
  begin
    if (link_hold)
      lp_r <= LPOS_RST;
    else
      lp_r <= lp_next;
  end

  // core: mode entry, pointer, loads and array requests
  always_comb
  begin
    c_next = c_r;
    c_next.req = 1'b0;
    c_next.tog_s = {c_r.tog_s[0], ln_r.tog};
    c_next.tog_prev = c_r.tog_s[1];
    c_next.hv_s = {c_r.hv_s[0], program_mode_select_hv_in};
    c_next.sel_s = {c_r.sel_s[0], program_mode_select_pin_in};
    c_next.lve_s = {c_r.lve_s[0], low_voltage_entry_pin_in};
    c_next.lvp_s = {c_r.lvp_s[0], low_voltage_programming_bit_in};
    ev = c_r.tog_s[1] ^ c_r.tog_prev;
    ev_kind = svp_decode(ln_r.ev_cmd);
    lv_ok = c_r.lvp_s[1] && c_r.lve_s[1] && c_r.sel_s[1];
    unique case (c_r.mode)
      MODE_OFF:
        if (lv_ok)
          c_next.mode = MODE_LV;
        else if (c_r.hv_s[1])
          c_next.mode = MODE_HV;
      MODE_HV:
        if (!c_r.hv_s[1])
          c_next.mode = MODE_OFF;
      MODE_LV:
        if (!lv_ok)
          c_next.mode = MODE_OFF;
    endcase
    if (c_r.mode == MODE_OFF)
    begin
      // pointer sits at zero until entry, so every entry starts there
      c_next.ptr = `SVP_PTR_RST;
      c_next.rd_pend = 1'b0;
      c_next.tog_s = 2'h0;
      c_next.tog_prev = 1'b0;
    end
    else if (ev)
    begin
      unique case (ev_kind)
        CMD_LD_CFG:
        begin
          c_next.ptr = `SVP_CFG_BASE;
          c_next.ld_word = ln_r.sh[`SVP_PAY_W:1];
          c_next.ld_dspace = 1'b0;
        end
        CMD_LD_PROG:
        begin
          c_next.ld_word = ln_r.sh[`SVP_PAY_W:1];
          c_next.ld_dspace = 1'b0;
        end
        CMD_LD_DATA:
        begin
          c_next.ld_word = {`SVP_PAD_ZERO6, ln_r.sh[`SVP_BYTE_W:1]};
          c_next.ld_dspace = 1'b1;
        end
        CMD_INC:
          c_next.ptr = ptr_inc(c_r.ptr);
        CMD_RD_PROG, CMD_RD_DATA:
        begin
          // built on the next state so synchronisers and mode keep moving
          c_next = issue(c_next, OP_READ, ev_kind == CMD_RD_DATA);
          c_next.rd_pend = 1'b1;
          c_next.rd_dspace = (ev_kind == CMD_RD_DATA);
          c_next.rd_id = c_r.ptr[`SVP_PTR_W-1] &&
                         (c_r.ptr[`SVP_ADDR_W-1:2] == `SVP_ID_HI_ZERO);
        end
        CMD_ERASE_PROG:
          c_next = issue(c_next, OP_ERASE_PROG, c_r.ld_dspace);
        CMD_PROG_ONLY:
          c_next = issue(c_next, OP_PROG_ONLY, c_r.ld_dspace);
        CMD_BULK_PROG:
          c_next = issue(c_next, OP_BULK_PROG, 1'b0);
        CMD_BULK_DATA:
          c_next = issue(c_next, OP_BULK_DATA, 1'b1);
        CMD_SETUP1:
          c_next = issue(c_next, OP_SETUP1, c_r.ld_dspace);
        CMD_SETUP2:
          c_next = issue(c_next, OP_SETUP2, c_r.ld_dspace);
        CMD_NOP:
          c_next.req = 1'b0;
      endcase
    end
    // read answer framed with zeros; data reads and id words escape protection
    if (c_r.rd_pend && nvm_rvalid_in && c_r.mode != MODE_OFF)
    begin
      // a read issued in this same cycle keeps its pending flag
      c_next.rd_pend = ev && svp_is_read(ev_kind);
      if (c_r.rd_dspace)
        c_next.rword = {`SVP_PAD_BIT, `SVP_PAD_ZERO6,
                        nvm_rdata_in[`SVP_BYTE_W-1:0], `SVP_PAD_BIT};
      else if (nvm_protect_in && !c_r.rd_id)
        c_next.rword = {`SVP_PAD_BIT, `SVP_ZERO_PAY, `SVP_PAD_BIT};
      else
        c_next.rword = {`SVP_PAD_BIT, nvm_rdata_in, `SVP_PAD_BIT};
    end
    c_next.hold = (c_next.mode != MODE_OFF);
    c_next.lv = (c_next.mode == MODE_LV);
    c_next.link_hold = (c_next.mode == MODE_OFF);
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      c_r <= CORE_RST;
    else
      c_r <= c_next;
  end

  // outputs, all from flops
  assign prog_data_out      = lp_r.dout;
  assign prog_data_oe_n_out = lp_r.oe_n;
  assign mode_active_out    = c_r.hold;
  assign core_hold_out      = c_r.hold;
  assign io_hiz_out         = c_r.hold;
  assign lv_mode_out        = c_r.lv;
  assign nvm_req_out        = c_r.req;
  assign nvm_op_out         = c_r.op;
  assign nvm_data_space_out = c_r.dspace;
  assign nvm_cfg_sel_out    = c_r.cfg_sel;
  assign nvm_addr_out       = c_r.addr;
  assign nvm_wdata_out      = c_r.wdata;

  // checks on the core side
  a_entry_ptr_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (c_r.mode == MODE_OFF && c_next.mode != MODE_OFF) |=> (c_r.ptr == `SVP_PTR_RST))
    else $error("pointer not zero after mode entry");
  a_cfg_stays_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (c_r.ptr[`SVP_PTR_W-1] && c_r.mode != MODE_OFF && c_next.mode != MODE_OFF)
    |=> c_r.ptr[`SVP_PTR_W-1])
    else $error("pointer left configuration space in mode");
  a_user_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ev && ev_kind == CMD_INC && c_r.mode != MODE_OFF && c_r.ptr == `SVP_USER_TOP)
    |=> (c_r.ptr == `SVP_PTR_RST))
    else $error("user pointer did not wrap to zero");
  a_cfg_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ev && ev_kind == CMD_INC && c_r.mode != MODE_OFF && c_r.ptr == `SVP_CFG_TOP)
    |=> (c_r.ptr == `SVP_CFG_BASE))
    else $error("configuration pointer did not wrap to base");
  a_ld_cfg_ptr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ev && ev_kind == CMD_LD_CFG && c_r.mode != MODE_OFF) |=> (c_r.ptr == `SVP_CFG_BASE))
    else $error("load configuration did not set pointer");
  a_nop_no_effect: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (ev && ev_kind == CMD_NOP && c_r.mode != MODE_OFF && !c_r.rd_pend)
    |=> ($stable(c_r.ptr) && !nvm_req_out && $stable(c_r.ld_word)))
    else $error("unlisted command had an effect");
  a_hold_tracks_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (core_hold_out == (c_r.mode != MODE_OFF)) && (io_hiz_out == core_hold_out) &&
    (mode_active_out == core_hold_out))
    else $error("device hold does not follow mode");
  // mode and its output flop load together, so the enable bit is one edge back
  a_lv_needs_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(lv_mode_out) |-> $past(c_r.lvp_s[1]))
    else $error("low voltage mode without enable bit");
  a_lv_keeps_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (c_r.mode == MODE_LV && lv_ok) |=> (c_r.mode == MODE_LV))
    else $error("low voltage mode overridden");
  a_cfg_map: assert property (@(posedge clk_in) disable iff (!resetn_in)
    nvm_req_out && nvm_cfg_sel_out |-> (nvm_addr_out[`SVP_ADDR_W-1:4] == `SVP_CFG_HI_ZERO))
    else $error("configuration select outside implemented words");

  // checks on the link side
  a_read_drive_on: assert property (@(posedge link_clk_in) disable iff (link_hold)
    (ln_r.phase == LK_DATA && ln_r.is_read && ln_r.cnt == `SVP_CNT_STEP)
    |=> !prog_data_oe_n_out)
    else $error("read data not driven at second rising edge");
  a_read_drive_off: assert property (@(posedge link_clk_in) disable iff (link_hold)
    (ln_r.phase == LK_CMD || !ln_r.is_read) |=> prog_data_oe_n_out)
    else $error("data pin driven outside a read");
  a_cmd_frame: assert property (@(negedge link_clk_in) disable iff (link_hold)
    (ln_r.phase == LK_CMD && ln_r.cnt == `SVP_CMD_LAST) |=> (ln_r.cnt == `SVP_CNT_RST))
    else $error("command frame not six bits");

endmodule : svp_port

// ### rtl/svp_consts.svh
`ifndef SVP_CONSTS_SVH
`define SVP_CONSTS_SVH

// frame geometry
`define SVP_CMD_W        6
`define SVP_WORD_W       16
`define SVP_PAY_W        14
`define SVP_PTR_W        14
`define SVP_ADDR_W       13
`define SVP_BYTE_W       8
`define SVP_DATA_ADDR_W  7
`define SVP_CNT_RST      5'h00
`define SVP_CNT_STEP     5'h01
`define SVP_CMD_LAST     5'h05
`define SVP_WORD_LAST    5'h0F

// pointer values
`define SVP_PTR_RST      14'h0000
`define SVP_PTR_STEP     13'h0001
`define SVP_CFG_BASE     14'h2000
`define SVP_USER_TOP     14'h1FFF
`define SVP_CFG_TOP      14'h3FFF
`define SVP_CFG_HI_ZERO  9'h000
`define SVP_ID_HI_ZERO   11'h000

// command codes, low four bits where the top two are don't-care
`define SVP_LO_LD_CFG    4'h0
`define SVP_LO_LD_PROG   4'h2
`define SVP_LO_LD_DATA   4'h3
`define SVP_LO_INC       4'h6
`define SVP_LO_RD_PROG   4'h4
`define SVP_LO_RD_DATA   4'h5
`define SVP_LO_BULK_PROG 4'h9
`define SVP_LO_BULK_DATA 4'hB
// fully decoded codes, setup one on its low five bits only
`define SVP_C_ERASE_PROG 6'h08
`define SVP_C_PROG_ONLY  6'h18
`define SVP_C_SETUP2     6'h07
`define SVP_C_SETUP1_LO5 5'h01

// read word padding
`define SVP_PAD_BIT      1'b0
`define SVP_PAD_ZERO6    6'h00
`define SVP_ZERO_PAY     14'h0000
`define SVP_ZERO_ADDR    13'h0000
`define SVP_ZERO_WORD    16'h0000
`define SVP_ZERO_CMD     6'h00

// timing
`define SVP_CLK_MHZ      125
`define SVP_GAP_NS       1000
`define SVP_GAP_CYC      ((`SVP_GAP_NS * `SVP_CLK_MHZ) / 1000)
`define SVP_RD_LAT_MAX   4
`define SVP_SYNC_CYC     4

`endif

// ### rtl/svp_pkg.sv
package svp_pkg;
`include "svp_consts.svh"

  typedef enum logic [3:0] {
    CMD_NOP, CMD_LD_CFG, CMD_LD_PROG, CMD_LD_DATA, CMD_INC, CMD_RD_PROG,
    CMD_RD_DATA, CMD_ERASE_PROG, CMD_PROG_ONLY, CMD_BULK_PROG, CMD_BULK_DATA,
    CMD_SETUP1, CMD_SETUP2
  } svp_cmd_t;

  typedef enum logic [2:0] {
    OP_READ, OP_ERASE_PROG, OP_PROG_ONLY, OP_BULK_PROG, OP_BULK_DATA,
    OP_SETUP1, OP_SETUP2
  } svp_op_t;

  typedef enum logic [1:0] {MODE_OFF, MODE_HV, MODE_LV} svp_mode_t;
  typedef enum logic {LK_CMD, LK_DATA} svp_phase_t;

  // falling-edge side of the link
  typedef struct packed {
    svp_phase_t                 phase;
    logic [4:0]                 cnt;
    logic [`SVP_CMD_W-1:0]      cmd;
    logic [`SVP_WORD_W-1:0]     sh;
    logic                       is_read;
    logic [`SVP_CMD_W-1:0]      ev_cmd;
    logic                       tog;
  } svp_lneg_t;

  // rising-edge side of the link
  typedef struct packed {
    logic dout;
    logic oe_n;
  } svp_lpos_t;

  // core clock side
  typedef struct packed {
    svp_mode_t                  mode;
    logic [`SVP_PTR_W-1:0]      ptr;
    logic [`SVP_PAY_W-1:0]      ld_word;
    logic                       ld_dspace;
    logic [`SVP_WORD_W-1:0]     rword;
    logic                       rd_pend;
    logic                       rd_dspace;
    logic                       rd_id;
    logic [1:0]                 tog_s;
    logic                       tog_prev;
    logic [1:0]                 hv_s;
    logic [1:0]                 sel_s;
    logic [1:0]                 lve_s;
    logic [1:0]                 lvp_s;
    logic                       link_hold;
    logic                       hold;
    logic                       lv;
    logic                       req;
    svp_op_t                    op;
    logic                       dspace;
    logic                       cfg_sel;
    logic [`SVP_ADDR_W-1:0]     addr;
    logic [`SVP_PAY_W-1:0]      wdata;
  } svp_core_t;

  function automatic svp_cmd_t svp_decode(input logic [`SVP_CMD_W-1:0] c);
    svp_cmd_t k;
    k = CMD_NOP;
    if (c == `SVP_C_ERASE_PROG) k = CMD_ERASE_PROG;
    else if (c == `SVP_C_PROG_ONLY) k = CMD_PROG_ONLY;
    else if (c == `SVP_C_SETUP2) k = CMD_SETUP2;
    else if (c[4:0] == `SVP_C_SETUP1_LO5) k = CMD_SETUP1;
    else
      case (c[3:0])
        `SVP_LO_LD_CFG:    k = CMD_LD_CFG;
        `SVP_LO_LD_PROG:   k = CMD_LD_PROG;
        `SVP_LO_LD_DATA:   k = CMD_LD_DATA;
        `SVP_LO_INC:       k = CMD_INC;
        `SVP_LO_RD_PROG:   k = CMD_RD_PROG;
        `SVP_LO_RD_DATA:   k = CMD_RD_DATA;
        `SVP_LO_BULK_PROG: k = CMD_BULK_PROG;
        `SVP_LO_BULK_DATA: k = CMD_BULK_DATA;
        default:           k = CMD_NOP;
      endcase
    return k;
  endfunction : svp_decode

  function automatic logic svp_is_read(input svp_cmd_t k);
    return (k == CMD_RD_PROG) || (k == CMD_RD_DATA);
  endfunction : svp_is_read

  function automatic logic svp_has_data(input svp_cmd_t k);
    return svp_is_read(k) || (k == CMD_LD_CFG) || (k == CMD_LD_PROG) ||
           (k == CMD_LD_DATA);
  endfunction : svp_has_data

endpackage : svp_pkg

// ### sim/svp_prog_model.sv
`timescale 1ns/10ps
// stand-in for the external programmer: clock and data, 80 ns link period
module svp_prog_model (
  output logic      link_clk_out,
  output logic      line_out,
  input  wire logic dev_data_in,
  input  wire logic dev_oe_n_in
);
  logic drv;
  // resolved data wire: the device wins while its enable is low
  assign line_out = dev_oe_n_in ? drv : dev_data_in;
  // clock and data low before any mode entry
  initial
  begin
    link_clk_out = 1'b0;
    drv = 1'b0;
  end
  // one pulse: bit set after rising edge, line sampled at falling edge
  task automatic pulse(input logic b, input logic rel, output logic got);
    link_clk_out = 1'b1;
    drv = rel ? ~drv : b; // released line toggles so a stale value never passes
    #40;
    link_clk_out = 1'b0;
    got = line_out;
    #40;
  endtask : pulse
  // one frame; clock stands still low in the gaps
  task automatic frame(input logic [5:0] c, input logic hw, input logic rd,
                       input logic [15:0] w, output logic [15:0] r);
    logic g;
    r = 16'h0000;
    for (int i = 0; i < 6; i++)
      pulse(c[i], 1'b0, g);
    #1200;
    if (hw)
      for (int i = 0; i < 16; i++)
      begin
        pulse(w[i], rd, g);
        r[i] = g;
      end
    drv = 1'b0;
    #1200;
  endtask : frame
endmodule : svp_prog_model

// ### sim/svp_port_test.sv
`timescale 1ns/10ps
module svp_port_test;
  import svp_pkg::*;
  logic        clk_in = 1'b0, resetn_in = 1'b0, rvalid = 1'b0, prot = 1'b0;
  logic        link_clk, line, dout, oe_n, hv, sel, lve, low_voltage_programming_bit, act, lvm, hold, hiz;
  logic        req, dsp, cfg;
  svp_op_t     op;
  logic [12:0] addr;
  logic [13:0] wdata, rdata = 14'h0000, rd_val, w;
  logic [15:0] r;
  logic [5:0]  codes [4] = '{6'h09, 6'h0B, 6'h01, 6'h07};
  logic [5:0]  msk [4] = '{6'h30, 6'h30, 6'h20, 6'h00};
  svp_op_t     ops [4] = '{OP_BULK_PROG, OP_BULK_DATA, OP_SETUP1, OP_SETUP2};
  int          n_errors = 0, compares = 0, n_req = 0, cyc = 0, k0;
  always #4 clk_in = ~clk_in;
  svp_port #(.DATA_ADDR_BITS(7), .RD_LAT_MAX(4)) dut_u (.clk_in(clk_in),
    .resetn_in(resetn_in), .link_clk_in(link_clk), .prog_data_in(line),
    .prog_data_out(dout), .prog_data_oe_n_out(oe_n), .program_mode_select_hv_in(hv),
    .program_mode_select_pin_in(sel), .low_voltage_entry_pin_in(lve),
    .low_voltage_programming_bit_in(low_voltage_programming_bit), .mode_active_out(act), .lv_mode_out(lvm),
    .core_hold_out(hold), .io_hiz_out(hiz), .nvm_req_out(req), .nvm_op_out(op),
    .nvm_data_space_out(dsp), .nvm_cfg_sel_out(cfg), .nvm_addr_out(addr),
    .nvm_wdata_out(wdata), .nvm_rvalid_in(rvalid), .nvm_rdata_in(rdata),
    .nvm_protect_in(prot));
  svp_prog_model prog_u (.link_clk_out(link_clk), .line_out(line), .dev_data_in(dout),
    .dev_oe_n_in(oe_n));
  // array stand-in: reads answered one cycle on; also the hang guard
  always @(negedge clk_in)
  begin
    rvalid <= req && (op === OP_READ);
    rdata <= rd_val;
    if (req === 1'b1)
      n_req++;
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one compare per kind of result: serial word, array request, mode status
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    chk(got, exp);
  endtask : chk_word
  task automatic chk_req(input logic [15:0] got, input logic [15:0] exp);
    chk(got, exp);
  endtask : chk_req
  task automatic chk_mode(input logic [15:0] got, input logic [15:0] exp);
    chk(got, exp);
  endtask : chk_mode
  task automatic cmd(input logic [5:0] c);
    prog_u.frame(c, 1'b0, 1'b0, 16'h0000, r);
  endtask : cmd
  // payload framed by two zero bits
  task automatic load(input logic [3:0] lo, input logic [13:0] p);
    prog_u.frame({2'($urandom), lo}, 1'b1, 1'b0, {1'b0, p, 1'b0}, r);
  endtask : load
  task automatic read(input logic [3:0] lo, input logic [13:0] v);
    rd_val = v;
    prog_u.frame({2'($urandom), lo}, 1'b1, 1'b1, 16'h0000, r);
    r[0] = 1'b0; // bit 0 is never driven, only its slot counts
  endtask : read
  // entry pins change on a falling edge; entry pin low for high voltage
  task automatic enter(input logic h, input logic b);
    @(negedge clk_in);
    hv <= h;
    low_voltage_programming_bit <= b;
    lve <= ~h;
    sel <= 1'b1;
    repeat (20) @(negedge clk_in);
  endtask : enter
  initial
  begin
    {hv, sel, lve, low_voltage_programming_bit} = 4'h0;
    rd_val = 14'h0000;
    void'($urandom(32'h2A39EA64));
    repeat (3) @(negedge clk_in);
    resetn_in <= 1'b1;
    enter(1'b1, 1'b0);
    chk_mode({hold, hiz, act}, 16'h0007);
    for (int i = 0; i < 4; i++)
    begin
      prot = i[0];
      read(4'h4, 14'($urandom));
      chk_word(r, prot ? 16'h0000 : {1'b0, rd_val, 1'b0});
      chk_req(16'(addr), 16'(i));
      cmd({2'($urandom), 4'h6});
    end
    $display("test read_increment done");
    cmd(6'h09);
    for (int i = 0; i < 2; i++)
    begin
      w = 14'($urandom);
      load(4'h2, w);
      cmd(i ? 6'h18 : 6'h08);
      chk_req({op, dsp}, {i ? OP_PROG_ONLY : OP_ERASE_PROG, 1'b0});
      chk_req(16'(wdata), 16'(w));
    end
    w = 14'($urandom) & 14'h00FF;
    load(4'h3, w);
    cmd(6'h08);
    chk_req({dsp, 1'b0, wdata}, {2'b10, w});
    read(4'h5, 14'($urandom));
    chk_word(r, {7'h00, rd_val[7:0], 1'b0});
    chk_req({dsp, 2'(0), addr}, 16'h8004);
    $display("test load_program done");
    for (int k = 0; k < 4; k++)
    begin
      k0 = n_req;
      cmd(codes[k] | (6'($urandom) & msk[k]));
      chk_req({8'(op), 8'(n_req - k0)}, {8'(ops[k]), 8'h01});
    end
    k0 = n_req;
    cmd(6'h0A);
    cmd(6'h3C);
    chk_req(16'(n_req - k0), 16'h0000);
    $display("test codes done");
    load(4'h0, 14'($urandom));
    prot = 1'b1;
    read(4'h4, 14'($urandom));
    chk_word(r, {1'b0, rd_val, 1'b0});
    chk_req({cfg, 2'(0), addr}, 16'h8000);
    repeat (4) cmd(6'h06);
    read(4'h4, 14'($urandom));
    chk_word({r[15:1], cfg}, 16'h0001);
    chk_req(16'(addr), 16'h0004);
    $display("test config_space done");
    enter(1'b0, 1'b0);
    chk_mode({act, lvm}, 16'h0000);
    enter(1'b0, 1'b1);
    chk_mode({act, lvm, hold}, 16'h0007);
    read(4'h4, 14'($urandom));
    chk_req({cfg, 2'(0), addr}, 16'h0000);
    @(negedge clk_in);
    hv <= 1'b1;
    repeat (20) @(negedge clk_in);
    chk_mode({act, lvm}, 16'h0003);
    $display("test low_voltage done");
    report_and_stop();
  end
endmodule : svp_port_test
